// *** hw/lk_fwd.sv ***
// Purpose: steers each received packet head to static target or router
// Assumes: at most one head per cycle, tagged with its physical link
// Notes: outputs appear one cycle after the head
`timescale 1ns/1ps
`default_nettype none
module lk_fwd (
    input  wire logic                                  clk,       // clock
    input  wire logic                                  rst,       // reset
    input  wire logic                                  head,      // head arrives
    input  wire logic [2:0]                            head_link, // its link
    input  wire logic [lk_pkg::NLINK-1:0]              st_en,     // by reg idx
    input  wire logic [lk_pkg::NLINK-1:0]              st_proc,   // by reg idx
    input  wire logic [lk_pkg::NLINK*lk_pkg::CHW-1:0]  st_chan,   // by reg idx
    output logic                                       fwd_valid, // static hit
    output logic                                       fwd_proc,  // processor
    output logic [lk_pkg::CHW-1:0]                     fwd_chan,  // chan end
    output logic                                       rt_valid,  // to router
    output logic [2:0]                                 out_link   // source link
);
    typedef struct packed {
        logic                   fv;
        logic                   fp;
        logic [lk_pkg::CHW-1:0] fc;
        logic                   rv;
        logic [2:0]             lnk;
    } lk_fwd_t;

    lk_fwd_t r_reg;
    lk_fwd_t r_next;
    lk_pkg::lk_idx_t ix;

    always_comb
    begin
        ix = lk_pkg::lk_st_index(head_link); // RL14
        r_next = r_reg;
        r_next.fv = head && st_en[ix]; // RL11
        r_next.rv = head && !st_en[ix];
        if (head)
        begin
            r_next.lnk = head_link;
            r_next.fp = st_proc[ix]; // RL12
            r_next.fc = st_chan[ix*lk_pkg::CHW +: lk_pkg::CHW]; // RL13
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign fwd_valid = r_reg.fv;
    assign fwd_proc = r_reg.fp;
    assign fwd_chan = r_reg.fc;
    assign rt_valid = r_reg.rv;
    assign out_link = r_reg.lnk;
endmodule
`default_nettype wire

// *** hw/lk_pace.sv ***
// Purpose: spaces transmit symbols and tokens of one link
// Assumes: requester holds req until go, drops it the cycle after go
// Notes: go is registered; gap counted in idle clocks after the go cycle
`timescale 1ns/1ps
`default_nettype none
module lk_pace (
    input  wire logic                    clk,     // system clock
    input  wire logic                    rst,     // async reset, high
    input  wire logic                    allow,   // enabled and credit held
    input  wire logic                    req,     // symbol wants to go
    input  wire logic                    last,    // symbol ends a token
    input  wire logic [lk_pkg::GAPW-1:0] sym_gap, // gap inside token
    input  wire logic [lk_pkg::GAPW-1:0] tok_gap, // gap between tokens
    output logic                         go       // symbol sent this cycle
);
    typedef struct packed {
        logic                    go;
        logic [lk_pkg::CNTW-1:0] cnt;
    } lk_pace_t;

    lk_pace_t r_reg;
    lk_pace_t r_next;

    always_comb
    begin
        r_next = r_reg;
        r_next.go = 1'b0;
        if (r_reg.cnt != '0)
        begin
            r_next.cnt = r_reg.cnt - 12'h001;
        end
        if (req && allow && !r_reg.go && r_reg.cnt == '0) // RL5
        begin
            r_next.go = 1'b1;
            if (last)
            begin
                r_next.cnt = {1'b0, tok_gap} + 12'h001; // RL9
            end
            else
            begin
                r_next.cnt = {1'b0, sym_gap} + 12'h001; // RL8
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign go = r_reg.go;
endmodule
`default_nettype wire

// *** hw/lk_top.sv ***
// Purpose: link configuration, credit state, pacing and static forward
// Assumes: register port reads answer in the next cycle, never wait
// Notes: link vectors are indexed by physical link, A..H as 0..7
`timescale 1ns/1ps
`default_nettype none
module lk_top (
    input  wire logic                       clk,         // 25 MHz clock
    input  wire logic                       rst,         // async reset, high
    input  wire logic [7:0]                 addr,        // register number
    input  wire logic [31:0]                wdata,       // write data
    input  wire logic                       wr,          // write strobe
    input  wire logic                       rd,          // read strobe
    output logic      [31:0]                rdata,       // read data
    output logic                            irq,         // level interrupt
    output logic      [lk_pkg::NLINK-1:0]   link_en,     // link enabled
    output logic      [lk_pkg::NLINK-1:0]   wire_width_select, // 1: five wire
    output logic      [lk_pkg::NLINK-1:0]   credit_restart_action, // hello
    output logic      [lk_pkg::NLINK-1:0]   rx_restart,  // receiver reset
    input  wire logic [lk_pkg::NLINK-1:0]   rx_overflow, // buffer overflow
    input  wire logic [lk_pkg::NLINK-1:0]   rx_bad_tok,  // illegal token
    input  wire logic [lk_pkg::NLINK-1:0]   credit_in,   // credit received
    input  wire logic [lk_pkg::NLINK-1:0]   credit_out,  // credit issued
    input  wire logic [lk_pkg::NLINK-1:0]   source_side_busy, // src in use
    input  wire logic [lk_pkg::NLINK-1:0]   dest_side_busy,   // dst in use
    input  wire logic [lk_pkg::NLINK-1:0]   sym_req,     // symbol waiting
    input  wire logic [lk_pkg::NLINK-1:0]   sym_last,    // last of token
    output logic      [lk_pkg::NLINK-1:0]   sym_go,      // symbol sent
    input  wire logic                       head,        // packet head in
    input  wire logic [2:0]                 head_link,   // its link
    output logic                            fwd_valid,   // static delivery
    output logic                            fwd_proc,    // dest processor
    output logic      [lk_pkg::CHW-1:0]     fwd_chan,    // dest chan end
    output logic                            rt_valid,    // needs routing
    output logic      [2:0]                 out_link     // link of head
);
    localparam int N = lk_pkg::NLINK;
    localparam int GW = lk_pkg::GAPW;
    localparam int CW = lk_pkg::CHW;

    typedef struct packed {
        logic [N-1:0]       en;
        logic [N-1:0]       wide;
        logic [N-1:0][GW-1:0] sgap;
        logic [N-1:0][GW-1:0] tgap;
        logic [N-1:0]       rx_err;
        logic [N-1:0]       rx_cr;
        logic [N-1:0]       tx_cr;
        logic [N-1:0]       hello;
        logic [N-1:0]       rxrst;
        logic [N-1:0]       st_en;
        logic [N-1:0]       st_proc;
        logic [N-1:0][CW-1:0] st_chan;
        logic [2*N-1:0]     sts;
        logic [2*N-1:0]     mask;
        logic [2*N-1:0]     busy;
        logic               irq;
        logic [31:0]        rdata;
    } lk_top_t;

    lk_top_t r_reg;
    lk_top_t r_next;
    lk_pkg::lk_idx_t ix;
    logic wr_cfg;
    logic wr_st;
    logic [N-1:0] err_ev;
    logic [N*CW-1:0] chan_flat;

    always_comb
    begin
        ix = addr[2:0];
        wr_cfg = wr && lk_pkg::lk_in_blk(addr, lk_pkg::CFG_BASE); // RL10
        wr_st = wr && lk_pkg::lk_in_blk(addr, lk_pkg::ST_BASE);
        err_ev = rx_overflow | rx_bad_tok;
        r_next = r_reg;
        // action bits never hold: they are high in the cycle after the write and drop in the next
        r_next.hello = '0; // RL16
        r_next.rxrst = '0; // RL16
        r_next.rdata = '0;
        r_next.busy = {dest_side_busy, source_side_busy}; // RL15

        if (wr_cfg)
        begin
            r_next.en[ix] = wdata[lk_pkg::B_EN]; // RL1
            r_next.wide[ix] = wdata[lk_pkg::B_WIDE]; // RL2
            r_next.hello[ix] = wdata[lk_pkg::B_HELLO]; // RL6
            r_next.rxrst[ix] = wdata[lk_pkg::B_RXRST]; // RL7
            r_next.sgap[ix] = wdata[lk_pkg::B_SYMLO +: GW]; // RL8
            r_next.tgap[ix] = wdata[lk_pkg::B_TOKLO +: GW]; // RL9
        end
        if (wr_st)
        begin
            r_next.st_en[ix] = wdata[lk_pkg::B_STEN]; // RL11
            r_next.st_proc[ix] = wdata[lk_pkg::B_PROC]; // RL12
            r_next.st_chan[ix] = wdata[lk_pkg::B_CHLO +: CW]; // RL13
        end
        if (wr && addr == lk_pkg::IRQ_MASK)
        begin
            r_next.mask = wdata[2*N-1:0];
        end

        // flags: an event in the same cycle as its clear still lands
        for (int i = 0; i < N; i++)
        begin
            if (r_next.hello[i])
            begin
                r_next.tx_cr[i] = 1'b0; // RL6
            end
            if (r_next.rxrst[i])
            begin
                r_next.rx_err[i] = 1'b0; // RL7
                r_next.rx_cr[i] = 1'b0;
            end
            if (credit_in[i])
            begin
                r_next.tx_cr[i] = 1'b1; // RL5
            end
            if (credit_out[i])
            begin
                r_next.rx_cr[i] = 1'b1; // RL4
            end
            if (err_ev[i])
            begin
                r_next.rx_err[i] = 1'b1; // RL3
            end
        end

        if (wr && addr == lk_pkg::IRQ_STS)
        begin
            r_next.sts = r_reg.sts & ~wdata[2*N-1:0];
        end
        r_next.sts = r_next.sts | {credit_in, err_ev};
        r_next.irq = |(r_next.sts & r_next.mask);

        if (rd)
        begin
            if (lk_pkg::lk_in_blk(addr, lk_pkg::CFG_BASE))
            begin
                r_next.rdata[lk_pkg::B_EN] = r_reg.en[ix]; // RL1
                r_next.rdata[lk_pkg::B_WIDE] = r_reg.wide[ix]; // RL2
                r_next.rdata[lk_pkg::B_RXERR] = r_reg.rx_err[ix]; // RL3
                r_next.rdata[lk_pkg::B_RXCR] = r_reg.rx_cr[ix]; // RL4
                r_next.rdata[lk_pkg::B_TXCR] = r_reg.tx_cr[ix]; // RL5
                r_next.rdata[lk_pkg::B_SYMLO +: GW] = r_reg.sgap[ix];
                r_next.rdata[lk_pkg::B_TOKLO +: GW] = r_reg.tgap[ix];
            end
            else if (lk_pkg::lk_in_blk(addr, lk_pkg::ST_BASE))
            begin
                r_next.rdata[lk_pkg::B_STEN] = r_reg.st_en[ix];
                r_next.rdata[lk_pkg::B_PROC] = r_reg.st_proc[ix];
                r_next.rdata[lk_pkg::B_CHLO +: CW] = r_reg.st_chan[ix];
            end
            else if (addr == lk_pkg::IRQ_STS)
            begin
                r_next.rdata[2*N-1:0] = r_reg.sts;
            end
            else if (addr == lk_pkg::IRQ_MASK)
            begin
                r_next.rdata[2*N-1:0] = r_reg.mask;
            end
            else if (addr == lk_pkg::BUSY_REG)
            begin
                r_next.rdata[2*N-1:0] = r_reg.busy; // RL15
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg <= '0;
            for (int i = 0; i < N; i++)
            begin
                r_reg.sgap[i] <= lk_pkg::GAP_RST;
                r_reg.tgap[i] <= lk_pkg::GAP_RST;
                r_reg.st_chan[i] <= lk_pkg::CH_RST;
            end
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign rdata = r_reg.rdata;
    assign irq = r_reg.irq;
    assign link_en = r_reg.en;
    assign wire_width_select = r_reg.wide;
    assign credit_restart_action = r_reg.hello;
    assign rx_restart = r_reg.rxrst;
    assign chan_flat = r_reg.st_chan;

    // a disabled link or one without credit never gets a symbol out
    for (genvar g = 0; g < N; g++)
    begin : pace
        lk_pace u_pace (
            .clk     (clk),
            .rst     (rst),
            .allow   (r_reg.en[g] && r_reg.tx_cr[g]),
            .req     (sym_req[g]),
            .last    (sym_last[g]),
            .sym_gap (r_reg.sgap[g]),
            .tok_gap (r_reg.tgap[g]),
            .go      (sym_go[g])
        );
    end

    lk_fwd u_fwd (
        .clk       (clk),
        .rst       (rst),
        .head      (head),
        .head_link (head_link),
        .st_en     (r_reg.st_en),
        .st_proc   (r_reg.st_proc),
        .st_chan   (chan_flat),
        .fwd_valid (fwd_valid),
        .fwd_proc  (fwd_proc),
        .fwd_chan  (fwd_chan),
        .rt_valid  (rt_valid),
        .out_link  (out_link)
    );
endmodule
`default_nettype wire

// *** pkg/lk_pkg.sv ***
// Purpose: constants for the external link config and static forward block
// Assumes: 8-bit register number on the plain port, one register per number
// Notes: physical links 0..7 stand for links A..H
// Contract
// RL1: bit 31 of a link register enables the link and picks pin muxing
// RL2: bit 30 picks two wires (0) or five wires (1), resets to zero
// RL3: read-only bit 27 flags receive overflow or an illegal token
// RL4: read-only bit 26 shows this end granted credit to remote
// RL5: read-only bit 25 shows held credit; transmit only while held
// RL6: writing one to bit 24 clears transmit credit and sends hello
// RL7: writing one to bit 23 resets receiver; next symbol starts a token
// RL8: at least field 21:11 plus one idle clocks between token symbols
// RL9: at least field 10:0 plus one idle clocks between tokens
// RL10: eight link registers, links zero to seven, contiguous from 0x80
// RL11: static enable sends all incoming traffic to the set channel end
// RL12: static bit 8 picks the destination processor, resets to zero
// RL13: static bits 4:0 pick the destination channel end, reset zero
// RL14: static registers in order serve links C, D, A, B, G, H, E, F
// RL15: per link read-only source and destination in-use flags
// RL16: write-only action bits pulse one cycle and read back zero
package lk_pkg;
    localparam int NLINK = 8;
    localparam int GAPW = 11;
    localparam int CHW = 5;
    localparam int CNTW = 12;
    localparam logic [7:0] CFG_BASE = 8'h80;
    localparam logic [7:0] ST_BASE = 8'ha0;
    localparam logic [7:0] IRQ_STS = 8'hc0;
    localparam logic [7:0] IRQ_MASK = 8'hc1;
    localparam logic [7:0] BUSY_REG = 8'hc2;
    localparam int B_EN = 31;
    localparam int B_WIDE = 30;
    localparam int B_RXERR = 27;
    localparam int B_RXCR = 26;
    localparam int B_TXCR = 25;
    localparam int B_HELLO = 24;
    localparam int B_RXRST = 23;
    localparam int B_SYMLO = 11;
    localparam int B_TOKLO = 0;
    localparam int B_STEN = 31;
    localparam int B_PROC = 8;
    localparam int B_CHLO = 0;
    localparam int B_DSTBUSY = 8;
    localparam logic [GAPW-1:0] GAP_RST = 11'h000;
    localparam logic [CHW-1:0] CH_RST = 5'h00;

    typedef logic [2:0] lk_idx_t;

    // register number of the static register that serves a physical link
    function automatic lk_idx_t lk_st_index(input lk_idx_t link);
        lk_st_index = link ^ 3'h2;
    endfunction

    // true when a register number falls in the block of eight at base
    function automatic logic lk_in_blk(input logic [7:0] a, input logic [7:0] base);
        lk_in_blk = (a[7:3] == base[7:3]);
    endfunction
endpackage

// *** sim/lk_props.sv ***
// Purpose: port assertions for lk_top
// Assumes: one clock domain, reset high
// Notes: gaps longer than one idle clock are measured by the bench
`timescale 1ns/1ps
`default_nettype none
module lk_props (
    input wire logic        clk,        // clock
    input wire logic        rst,        // reset
    input wire logic [7:0]  addr,       // reg
    input wire logic [31:0] wdata,      // data
    input wire logic        wr,         // write
    input wire logic        rd,         // read
    input wire logic [31:0] rdata,      // read data
    input wire logic [7:0]  link_en,    // enable
    input wire logic [7:0]  wire_width_select, // width
    input wire logic [7:0]  credit_restart_action, // hello
    input wire logic [7:0]  rx_restart, // rx reset
    input wire logic [7:0]  sym_req,    // request
    input wire logic [7:0]  sym_go,     // sent
    input wire logic        head,       // head
    input wire logic [2:0]  head_link,  // link
    input wire logic        fwd_valid,  // static
    input wire logic        rt_valid,   // routed
    input wire logic [2:0]  out_link    // link
);
    logic cfg_wr;
    assign cfg_wr = wr && lk_pkg::lk_in_blk(addr, lk_pkg::CFG_BASE);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_cfg; cfg_wr |=> {link_en[$past(addr[2:0])],
        wire_width_select[$past(addr[2:0])]} == $past(wdata[31:30]); endproperty
    a_cfg: assert property (p_cfg) else $error("enable or width not as written");
    property p_hello; cfg_wr && wdata[24] |=>
        credit_restart_action == (8'h01 << $past(addr[2:0])); endproperty
    a_hello: assert property (p_hello) else $error("hello pulse wrong");
    property p_rxrst; cfg_wr && wdata[23] |=>
        rx_restart == (8'h01 << $past(addr[2:0])); endproperty
    a_rxrst: assert property (p_rxrst) else $error("receiver reset pulse wrong");
    property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_go; (sym_go & ~$past(sym_req & link_en)) == 8'h00; endproperty
    a_go: assert property (p_go) else $error("symbol sent without request");
    property p_gap; (sym_go & $past(sym_go)) == 8'h00; endproperty
    a_gap: assert property (p_gap) else $error("no idle clock between symbols");
    property p_head; head |=> (fwd_valid ^ rt_valid) && out_link == $past(head_link);
    endproperty
    a_head: assert property (p_head) else $error("head not steered once");
    property p_idle; !head |=> !fwd_valid && !rt_valid; endproperty
    a_idle: assert property (p_idle) else $error("steering without head");
    c_fwd: cover property (fwd_valid);
    c_route: cover property (rt_valid);
    c_hello: cover property (credit_restart_action != 8'h00);
endmodule
bind lk_top lk_props u_lk_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link_en(link_en), .wire_width_select(wire_width_select),
    .credit_restart_action(credit_restart_action), .rx_restart(rx_restart),
    .sym_req(sym_req), .sym_go(sym_go), .head(head), .head_link(head_link),
    .fwd_valid(fwd_valid), .rt_valid(rt_valid), .out_link(out_link));
`default_nettype wire

// *** sim/lk_remote.sv ***
// Purpose: behavioural remote end of the eight links
// Assumes: shares the system clock with the local end
// Notes: a larger DLY makes a slow remote; the flags must not show early
`timescale 1ns/1ps
`default_nettype none
module lk_remote #(
    parameter int DLY = 3
) (
    input  wire logic       clk,        // clock
    input  wire logic       rst,        // reset
    input  wire logic [7:0] hello,      // hello seen
    input  wire logic [7:0] rx_restart, // local rx reset
    input  wire logic [7:0] bad_cmd,    // send bad token
    output logic      [7:0] credit_in,  // credit given
    output logic      [7:0] credit_out, // credit taken
    output logic      [7:0] rx_bad_tok  // bad token
);
    logic [DLY-1:0][7:0] hello_reg;
    logic [DLY-1:0][7:0] grant_reg;
    assign credit_in = hello_reg[DLY-1];
    assign credit_out = grant_reg[DLY-1];
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hello_reg <= '0;
            grant_reg <= '0;
            rx_bad_tok <= 8'h00;
        end
        else
        begin
            hello_reg <= {hello_reg[DLY-2:0], hello};
            grant_reg <= {grant_reg[DLY-2:0], rx_restart};
            rx_bad_tok <= bad_cmd;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: self-checking bench for lk_top
// Assumes: remote model answers hello and rx reset after DLY clocks
// Notes: reads and heads are scored from queues by a watcher
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int DLY = 3;
    logic        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, head = 1'h0, rd_q = 1'h0;
    logic [7:0]  addr = 8'h0, ovf = 8'h0, bad_cmd = 8'h0, sym_req = 8'h0, sym_last = 8'h0;
    logic [7:0]  src = 8'h0, dst = 8'h0, en, wide, hello, rxr, cin, cout, bad, go;
    logic [31:0] wdata = 32'h0, rdata, w;
    logic [31:0] cfg [8];
    logic [31:0] rq [$];
    logic [6:0]  fq [$];
    logic [6:0]  e;
    logic [2:0]  head_link = 3'h0, out_link;
    // static register number of links a..h, taken from the register order c d a b g h e f
    logic [7:0][2:0] st_of = {3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};
    logic [4:0]  fwd_chan;
    logic        irq, fwd_valid, fwd_proc, rt_valid, lastp;
    int          fail_count = 0, samples_checked = 0, cyc = 0, prev = 0, seed = 38;
    lk_top u_lk_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .link_en(en), .wire_width_select(wide),
        .credit_restart_action(hello), .rx_restart(rxr), .rx_overflow(ovf),
        .rx_bad_tok(bad), .credit_in(cin), .credit_out(cout), .source_side_busy(src),
        .dest_side_busy(dst), .sym_req(sym_req), .sym_last(sym_last), .sym_go(go),
        .head(head), .head_link(head_link), .fwd_valid(fwd_valid), .fwd_proc(fwd_proc),
        .fwd_chan(fwd_chan), .rt_valid(rt_valid), .out_link(out_link));
    lk_remote #(.DLY(DLY)) u_lk_remote (.clk(clk), .rst(rst), .hello(hello),
        .rx_restart(rxr), .bad_cmd(bad_cmd), .credit_in(cin), .credit_out(cout),
        .rx_bad_tok(bad));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        rq.push_back(x);
        @(posedge clk);
        rd <= 1'h0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // read data live only in the cycle after the strobe
    always @(posedge clk)
    begin
        rd_q <= rd;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done;
        end
    end
    always @(negedge clk)
    begin
        if (rd_q)
            chk(rdata, rq.pop_front());
        if (fwd_valid || rt_valid)
        begin
            e = fq.pop_front();
            chk({fwd_valid, rt_valid}, {e[6], !e[6]});
            if (e[6])
                chk({fwd_proc, fwd_chan}, e[5:0]);
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            rreg(lk_pkg::CFG_BASE + 8'(i), 32'h0);
            rreg(lk_pkg::ST_BASE + 8'(i), 32'h0);
        end
        wreg(8'h88, 32'hffff_ffff);
        rreg(8'h88, 32'h0);
        for (int i = 1; i < 8; i++)
        begin
            cfg[i] = $random(seed) & 32'hc03f_ffff;
            // link 3 stays enabled so that only missing credit can hold it back
            if (i == 3)
                cfg[i][31] = 1'h1;
            wreg(lk_pkg::CFG_BASE + 8'(i), cfg[i]);
        end
        wreg(lk_pkg::CFG_BASE, 32'h8100_1004);
        repeat (DLY + 3) @(posedge clk);
        rreg(lk_pkg::CFG_BASE, 32'h8200_1004);
        for (int i = 1; i < 8; i++)
            rreg(lk_pkg::CFG_BASE + 8'(i), cfg[i]);
        w = 32'h0000_0001;
        for (int i = 1; i < 8; i++)
        begin
            w[i] = cfg[i][31];
            w[8 + i] = cfg[i][30];
        end
        chk({16'h0, wide, en}, w);
        @(posedge clk);
        ovf <= 8'h02;
        bad_cmd <= 8'h04;
        @(posedge clk);
        ovf <= 8'h00;
        bad_cmd <= 8'h00;
        repeat (3) @(posedge clk);
        rreg(8'h81, cfg[1] | 32'h0800_0000);
        rreg(8'h82, cfg[2] | 32'h0800_0000);
        rreg(lk_pkg::IRQ_STS, 32'h0000_0106);
        wreg(lk_pkg::IRQ_MASK, 32'h0000_0004);
        repeat (2) @(negedge clk);
        chk(irq, 1'h1);
        wreg(lk_pkg::IRQ_STS, 32'h0000_0004);
        repeat (2) @(negedge clk);
        chk(irq, 1'h0);
        wreg(8'h81, cfg[1] | 32'h0080_0000);
        repeat (DLY + 3) @(posedge clk);
        rreg(8'h81, cfg[1] | 32'h0400_0000);
        w = $random(seed);
        @(posedge clk);
        src <= w[7:0];
        dst <= w[15:8];
        rreg(lk_pkg::BUSY_REG, {16'h0, w[15:0]});
        sym_req <= 8'h09;
        for (int n = 0; n < 8; n++)
        begin
            do
                @(negedge clk);
            while (go[0] !== 1'h1);
            chk(go[3], 1'h0);
            if (n > 0)
                chk(cyc - prev >= (lastp ? 6 : 4), 1'h1);
            lastp = sym_last[0];
            prev = cyc;
            @(posedge clk);
            sym_last <= {7'h0, n[0]};
        end
        sym_req <= 8'h00;
        // a second hello drops the held credit before the remote answers again
        wreg(lk_pkg::CFG_BASE, 32'h8100_1004);
        rreg(lk_pkg::CFG_BASE, 32'h8000_1004);
        for (int l = 0; l < 8; l++)
        begin
            w = $random(seed);
            w[31] = l[0];
            wreg(lk_pkg::ST_BASE + {5'h0, st_of[l]}, w);
            rreg(lk_pkg::ST_BASE + {5'h0, st_of[l]}, w & 32'h8000_011f);
            @(posedge clk);
            head <= 1'h1;
            head_link <= 3'(l);
            fq.push_back({w[31], w[8], w[4:0]});
            @(posedge clk);
            head <= 1'h0;
        end
        repeat (4) @(posedge clk);
        chk(fq.size(), 32'h0);
        test_done;
    end
endmodule
`default_nettype wire
